// >>> pmrp_pkg.sv
package pmrp_pkg;
    localparam int PMRP_ADDR_LSB   = 13;
    localparam int PMRP_ADDR_MSB   = 35;
    localparam int PMRP_ADDR_W     = PMRP_ADDR_MSB - PMRP_ADDR_LSB + 1;
    localparam int PMRP_DATA_W     = 36;
    localparam int PMRP_DIAG_W     = 3;
    localparam int PMRP_OP_W       = 4;
    localparam logic [2:0] PMRP_DIAG_XFER = 3'h7;
    localparam logic [PMRP_DATA_W-1:0] PMRP_DATA_RST = 36'h0_0000_0000;
    localparam logic [PMRP_ADDR_W-1:0] PMRP_ADDR_RST = 23'h00_0000;
    // Operation codes presented by the user port.
    localparam logic [3:0] PMRP_OP_READ      = 4'h0;
    localparam logic [3:0] PMRP_OP_WRITE     = 4'h1;
    localparam logic [3:0] PMRP_OP_LD_UBR    = 4'h2;
    localparam logic [3:0] PMRP_OP_LD_EBR    = 4'h3;
    localparam logic [3:0] PMRP_OP_LD_CCA    = 4'h4;
    localparam logic [3:0] PMRP_OP_LD_REFILL = 4'h5;
    localparam logic [3:0] PMRP_OP_RD_UBR    = 4'h6;
    localparam logic [3:0] PMRP_OP_RD_EBR    = 4'h7;
    localparam logic [3:0] PMRP_OP_RD_CCA    = 4'h8;
    localparam logic [3:0] PMRP_OP_RD_ERA    = 4'h9;
    localparam logic [3:0] PMRP_OP_RD_PT     = 4'hA;
    // Qualifier bit positions.
    localparam int PMRP_Q_WRITE   = 0;
    localparam int PMRP_Q_LOAD    = 1;
    localparam int PMRP_Q_READ    = 2;
    localparam int PMRP_Q_UBR     = 3;
    localparam int PMRP_Q_EBR     = 4;
    localparam int PMRP_Q_CCA     = 5;
    localparam int PMRP_Q_ERA     = 6;
    localparam int PMRP_Q_MAP     = 7;
    localparam int PMRP_Q_REFILL  = 8;
    localparam int PMRP_QUAL_W    = 9;
    typedef enum logic [1:0] {
        PMRP_IDLE,
        PMRP_REQ,
        PMRP_WAIT_RESP,
        PMRP_SYNC
    } pmrp_state_e;
endpackage : pmrp_pkg

// >>> pmrp_parity.sv
module pmrp_parity
    import pmrp_pkg::*;
#(
    parameter int WIDTH = PMRP_DATA_W
) (
    // Data in.
    input  wire logic [WIDTH-1:0] data,
    // Odd parity bit and check against a supplied bit.
    input  wire logic             par_in,
    output logic                  par_odd,
    output logic                  par_ok
);
    if (WIDTH < 1) begin : g_bad_width
        $error("pmrp_parity width must be positive.");
    end
    assign par_odd = ~(^data);
    assign par_ok  = ((^data) ^ par_in) == 1'b1;
endmodule : pmrp_parity

// >>> pmrp_host.sv
module pmrp_host
    import pmrp_pkg::*;
#(
    parameter int ADDR_W = PMRP_ADDR_W,
    parameter int DATA_W = PMRP_DATA_W
) (
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              nrst,
    // User command port.
    input  wire logic              cmd_valid,
    input  wire logic [3:0]        cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    input  wire logic              cmd_abort,
    output logic                   cmd_ready,
    output logic                   cmd_done,
    output logic                   cmd_aborted,
    output logic [DATA_W-1:0]      cmd_rdata,
    output logic                   cmd_par_err,
    // Request handshake toward the storage controller.
    output logic                   proc_request,
    output logic                   abort_reference,
    output logic [PMRP_QUAL_W-1:0] req_qualifiers,
    output logic [ADDR_W-1:0]      virtual_address_bus,
    output logic [DATA_W-1:0]      arithmetic_register,
    output logic                   store_data_parity,
    output logic [PMRP_DIAG_W-1:0] diag_select_code,
    output logic                   data_sync_strobe,
    output logic                   master_reset,
    input  wire logic              start_acknowledge,
    input  wire logic              response_valid,
    input  wire logic [DATA_W-1:0] cache_data,
    input  wire logic              read_data_parity,
    // Error flag level that freezes the controller's error address.
    input  wire logic              proc_error_in,
    output logic                   any_proc_error_flag
);
    // The buses are fixed by the interface, so other widths are refused outright.
    if (ADDR_W != PMRP_ADDR_W) begin : g_bad_addr_w
        $error("pmrp_host address width must be 23.");
    end
    if (DATA_W != PMRP_DATA_W) begin : g_bad_data_w
        $error("pmrp_host data width must be 36.");
    end
    if (PMRP_Q_REFILL >= PMRP_QUAL_W) begin : g_bad_qual_w
        $error("pmrp_host qualifier field is too narrow.");
    end

    // Register loads carry their data on the address bus, so only the qualifiers differ.
    function automatic logic [PMRP_QUAL_W-1:0] op_qual(input logic [3:0] op);
        logic [PMRP_QUAL_W-1:0] q;
        q = '0;
        case (op)
            PMRP_OP_WRITE:     q[PMRP_Q_WRITE] = 1'b1;
            PMRP_OP_LD_UBR:    begin q[PMRP_Q_LOAD] = 1'b1; q[PMRP_Q_UBR] = 1'b1; end
            PMRP_OP_LD_EBR:    begin q[PMRP_Q_LOAD] = 1'b1; q[PMRP_Q_EBR] = 1'b1; end
            PMRP_OP_LD_CCA:    begin q[PMRP_Q_LOAD] = 1'b1; q[PMRP_Q_CCA] = 1'b1; end
            PMRP_OP_LD_REFILL: begin q[PMRP_Q_READ] = 1'b1; q[PMRP_Q_REFILL] = 1'b1; end
            PMRP_OP_RD_UBR:    begin q[PMRP_Q_READ] = 1'b1; q[PMRP_Q_UBR] = 1'b1; end
            PMRP_OP_RD_EBR:    begin q[PMRP_Q_READ] = 1'b1; q[PMRP_Q_EBR] = 1'b1; end
            PMRP_OP_RD_CCA:    begin q[PMRP_Q_READ] = 1'b1; q[PMRP_Q_CCA] = 1'b1; end
            PMRP_OP_RD_ERA:    begin q[PMRP_Q_READ] = 1'b1; q[PMRP_Q_ERA] = 1'b1; end
            PMRP_OP_RD_PT:     begin q[PMRP_Q_READ] = 1'b1; q[PMRP_Q_MAP] = 1'b1; end
            default:           q = '0;
        endcase
        return q;
    endfunction : op_qual

    function automatic logic op_is_reg_read(input logic [3:0] op);
        return (op >= PMRP_OP_RD_UBR) && (op <= PMRP_OP_RD_PT);
    endfunction : op_is_reg_read

    pmrp_state_e     state_reg;
    logic [3:0]      op_reg;
    logic            first_reg;
    logic            store_par;
    logic            rd_par_ok;

    pmrp_parity #(.WIDTH(DATA_W)) u_store_par (
        .data    (cmd_wdata),
        .par_in  (1'b0),
        .par_odd (store_par),
        .par_ok  ()
    );

    pmrp_parity #(.WIDTH(DATA_W)) u_read_par (
        .data    (cache_data),
        .par_in  (read_data_parity),
        .par_odd (),
        .par_ok  (rd_par_ok)
    );

    // The abort window is one period only; later aborts are ignored.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= PMRP_IDLE;
        end else begin
            case (state_reg)
                PMRP_IDLE: begin
                    if (cmd_valid) state_reg <= PMRP_REQ;
                end
                PMRP_REQ: begin
                    if (start_acknowledge) state_reg <= PMRP_WAIT_RESP;
                    else if (first_reg && cmd_abort) state_reg <= PMRP_IDLE;
                    else state_reg <= PMRP_REQ;
                end
                PMRP_WAIT_RESP: begin
                    if (response_valid) state_reg <= PMRP_SYNC;
                end
                PMRP_SYNC: begin
                    state_reg <= PMRP_IDLE;
                end
                default: state_reg <= PMRP_IDLE;
            endcase
        end
    end

    // Marks the single period after the request rises, the only one in which abort is legal.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_reg <= 1'b0;
        end else begin
            first_reg <= (state_reg == PMRP_IDLE) && cmd_valid;
        end
    end

    // Request line and abort, both aligned to the shared clock.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            proc_request    <= 1'b0;
            abort_reference <= 1'b0;
        end else begin
            if (state_reg == PMRP_IDLE && cmd_valid) begin
                proc_request <= 1'b1;
            end else if (state_reg == PMRP_REQ && start_acknowledge) begin
                proc_request <= 1'b0;
            end else if (state_reg == PMRP_REQ && first_reg && cmd_abort) begin
                proc_request <= 1'b0;
            end
            abort_reference <= (state_reg == PMRP_REQ) && first_reg && cmd_abort
                               && !start_acknowledge;
        end
    end

    // Address, data and qualifiers are loaded with the request and frozen after.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            op_reg              <= 4'h0;
            req_qualifiers      <= '0;
            virtual_address_bus <= PMRP_ADDR_RST;
            arithmetic_register <= PMRP_DATA_RST;
            store_data_parity   <= 1'b1;
            diag_select_code    <= 3'h0;
        end else if (state_reg == PMRP_IDLE && cmd_valid) begin
            op_reg              <= cmd_op;
            req_qualifiers      <= op_qual(cmd_op);
            virtual_address_bus <= cmd_addr;
            arithmetic_register <= cmd_wdata;
            store_data_parity   <= store_par;
            diag_select_code    <= op_is_reg_read(cmd_op) ? PMRP_DIAG_XFER : 3'h0;
        end
    end

    // Sync strobe for exactly one tick once the response is seen.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            data_sync_strobe <= 1'b0;
            cmd_rdata        <= PMRP_DATA_RST;
            cmd_par_err      <= 1'b0;
            cmd_done         <= 1'b0;
            cmd_aborted      <= 1'b0;
        end else begin
            data_sync_strobe <= (state_reg == PMRP_WAIT_RESP) && response_valid;
            cmd_done         <= (state_reg == PMRP_WAIT_RESP) && response_valid;
            cmd_aborted      <= (state_reg == PMRP_REQ) && first_reg && cmd_abort
                                && !start_acknowledge;
            if (state_reg == PMRP_WAIT_RESP && response_valid) begin
                cmd_rdata <= cache_data;
                // Transfer-bus reads carry no parity, so they are never flagged.
                cmd_par_err <= !rd_par_ok && !op_is_reg_read(op_reg);
            end
        end
    end

    // Ready is registered so the user sees a clean idle level.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_ready           <= 1'b0;
            master_reset        <= 1'b1;
            any_proc_error_flag <= 1'b0;
        end else begin
            cmd_ready           <= (state_reg == PMRP_IDLE) && !cmd_valid;
            master_reset        <= 1'b0;
            any_proc_error_flag <= proc_error_in;
        end
    end
endmodule : pmrp_host

// >>> pmrp_host_monitor.sv
module pmrp_host_monitor
    import pmrp_pkg::*;
(
    // Clock, reset and handshake.
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cmd_abort,
    input wire logic proc_request,
    input wire logic abort_reference,
    input wire logic start_acknowledge,
    input wire logic response_valid,
    input wire logic data_sync_strobe,
    // Buses.
    input wire logic [PMRP_ADDR_W-1:0] virtual_address_bus,
    input wire logic [PMRP_DATA_W-1:0] arithmetic_register,
    input wire logic store_data_parity,
    input wire logic [PMRP_DATA_W-1:0] cache_data,
    input wire logic [PMRP_DATA_W-1:0] cmd_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    ack_clears_a: assert property (proc_request && start_acknowledge |=> !proc_request)
        else $error("request up after ack");
    req_holds_a: assert property (proc_request && !start_acknowledge
        && !($rose(proc_request) && cmd_abort) |=> proc_request) else $error("request dropped");
    abort_first_a: assert property (abort_reference |->
        $past(proc_request) && !$past(proc_request, 2) && !proc_request) else $error("bad abort");
    addr_stable_a: assert property (proc_request && !$rose(proc_request) |->
        $stable(virtual_address_bus) && $stable(arithmetic_register)) else $error("bus moved");
    odd_parity_a: assert property (proc_request |-> store_data_parity == ~^arithmetic_register)
        else $error("store parity wrong");
    sync_follows_a: assert property ($rose(response_valid) |=> data_sync_strobe)
        else $error("no sync after response");
    sync_pulse_a: assert property (data_sync_strobe |=> !data_sync_strobe)
        else $error("sync too long");
    rdata_take_a: assert property (data_sync_strobe |-> cmd_rdata == $past(cache_data))
        else $error("read data not captured");
endmodule : pmrp_host_monitor

bind pmrp_host pmrp_host_monitor mon (.mclk, .nrst, .cmd_abort, .proc_request, .abort_reference,
    .start_acknowledge, .response_valid, .data_sync_strobe, .virtual_address_bus,
    .arithmetic_register, .store_data_parity, .cache_data, .cmd_rdata);

// >>> pmrp_ctrl_model.sv
module pmrp_ctrl_model
    import pmrp_pkg::*;
(
    // Handshake from the host.
    input wire logic mclk,
    input wire logic nrst,
    input wire logic proc_request,
    input wire logic data_sync_strobe,
    input wire logic any_proc_error_flag,
    input wire logic [PMRP_QUAL_W-1:0] req_qualifiers,
    input wire logic [PMRP_ADDR_W-1:0] virtual_address_bus,
    // Answers.
    output logic start_acknowledge,
    output logic response_valid,
    output logic [PMRP_DATA_W-1:0] cache_data,
    output logic read_data_parity,
    // Bench knobs.
    input wire logic [3:0] ack_dly,
    input wire logic bad_par
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wcnt_reg;
    logic busy_reg;
    logic [PMRP_ADDR_W-1:0] ubr_reg, ebr_reg, cca_reg, era_reg, rfl_reg, a;
    logic [PMRP_QUAL_W-1:0] q;
    logic [PMRP_DATA_W-1:0] res_reg;
    assign q = req_qualifiers;
    assign a = virtual_address_bus;
    // Ack is combinational so that an idle controller answers in the request's own tick when ack_dly is 0.
    assign start_acknowledge = proc_request && !busy_reg && wcnt_reg >= ack_dly;
    assign read_data_parity = ~^cache_data ^ bad_par;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {wcnt_reg, busy_reg, response_valid} <= '0;
            {ubr_reg, ebr_reg, cca_reg, era_reg, rfl_reg, res_reg, cache_data} <= '0;
        end else begin
            wcnt_reg <= (proc_request && !start_acknowledge) ? wcnt_reg + 4'h1 : 4'h0;
            if (start_acknowledge) begin
                busy_reg <= 1'b1;
                if (q[PMRP_Q_LOAD] && q[PMRP_Q_UBR]) ubr_reg <= a;
                if (q[PMRP_Q_LOAD] && q[PMRP_Q_EBR]) ebr_reg <= a;
                if (q[PMRP_Q_LOAD] && q[PMRP_Q_CCA]) cca_reg <= a;
                if (q[PMRP_Q_REFILL]) rfl_reg <= a;
                if (q[8:3] == '0 && !any_proc_error_flag) era_reg <= a;
                res_reg <= q[PMRP_Q_UBR] ? {13'h0, ubr_reg} : q[PMRP_Q_EBR] ? {13'h0, ebr_reg}
                    : q[PMRP_Q_CCA] ? {13'h0, cca_reg} : q[PMRP_Q_ERA] ? {13'h0, era_reg}
                    : q[PMRP_Q_MAP] ? {13'h0, ~a} : {a[12:0], a};
            end
            if (busy_reg && !response_valid) begin
                response_valid <= 1'b1;
                cache_data <= res_reg;
            end
            if (response_valid && data_sync_strobe) begin
                {response_valid, busy_reg} <= 2'b00;
                cache_data <= ~cache_data;
            end
        end
    end
endmodule : pmrp_ctrl_model

// >>> pmrp_host_tb.sv
module pmrp_host_tb
    import pmrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_abort = 1'b0, bad_par = 1'b0;
    logic proc_error_in = 1'b0, fin, dn, pe, ar;
    logic [3:0] cmd_op = 4'h0, ack_dly = 4'h0;
    logic [PMRP_ADDR_W-1:0] cmd_addr = '0, virtual_address_bus;
    logic [PMRP_DATA_W-1:0] cmd_wdata = 36'h5_A5A5_0F0F, cmd_rdata, arithmetic_register;
    logic [PMRP_DATA_W-1:0] cache_data, got;
    logic cmd_ready, cmd_done, cmd_aborted, cmd_par_err, proc_request, abort_reference;
    logic store_data_parity, data_sync_strobe, master_reset, start_acknowledge, response_valid;
    logic read_data_parity, any_proc_error_flag;
    logic [PMRP_QUAL_W-1:0] req_qualifiers;
    logic [PMRP_DIAG_W-1:0] diag_select_code, dg;
    int bad_count = 0, cmp_count = 0;
    pmrp_host uut (.*);
    pmrp_ctrl_model dev (.*);
    always #10 mclk = ~mclk;
    task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic run(input logic [3:0] op, input logic [22:0] ad, input logic ab);
        chk("ready", cmd_ready, 1);
        cmd_op = op;
        cmd_addr = ad;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_abort = ab;
        @(negedge mclk);
        cmd_abort = 1'b0;
        dg = diag_select_code;
        ar = abort_reference;
        fin = cmd_aborted;
        for (int i = 0; i < 40 && !fin; i++) begin
            @(negedge mclk);
            fin = cmd_done || cmd_aborted;
        end
        {got, dn, pe} = {cmd_rdata, cmd_done, cmd_par_err};
        chk("finished", fin, 1);
        repeat (3) @(negedge mclk);
    endtask : run
    task automatic t_mem();
        for (int d = 0; d < 4; d += 3) begin
            ack_dly = 4'(d);
            run(PMRP_OP_READ, 23'h12_3456 + 23'(d), 1'b0);
            chk("mem data", got, {13'h1456 + 13'(d), 23'h12_3456 + 23'(d)});
            chk("parity clean", pe, 0);
        end
        run(PMRP_OP_WRITE, 23'h00_0ABC, 1'b0);
        chk("write done", dn, 1);
        $display("mem test done");
    endtask : t_mem
    task automatic t_regs();
        for (int i = 0; i < 3; i++) begin
            run(PMRP_OP_LD_UBR + 4'(i), 23'h2A_0000 + 23'(i), 1'b0);
            run(PMRP_OP_RD_UBR + 4'(i), 23'h0, 1'b0);
            chk("reg read", got, {13'h0, 23'h2A_0000 + 23'(i)});
            chk("diag code", dg, PMRP_DIAG_XFER);
        end
        run(PMRP_OP_RD_PT, 23'h01_0F00, 1'b0);
        chk("page entry", got, {13'h0, ~23'h01_0F00});
        run(PMRP_OP_LD_REFILL, 23'h00_0033, 1'b0);
        chk("refill done", dn, 1);
        $display("register test done");
    endtask : t_regs
    task automatic t_era();
        run(PMRP_OP_READ, 23'h33_3333, 1'b0);
        run(PMRP_OP_RD_ERA, 23'h0, 1'b0);
        chk("era", got, {13'h0, 23'h33_3333});
        proc_error_in = 1'b1;
        run(PMRP_OP_READ, 23'h44_4444, 1'b0);
        run(PMRP_OP_RD_ERA, 23'h0, 1'b0);
        chk("era frozen", got, {13'h0, 23'h33_3333});
        proc_error_in = 1'b0;
        $display("error address test done");
    endtask : t_era
    task automatic t_abort();
        ack_dly = 4'h2;
        run(PMRP_OP_READ, 23'h00_1111, 1'b1);
        chk("aborted done", dn, 0);
        chk("abort line", ar, 1);
        ack_dly = 4'h0;
        run(PMRP_OP_READ, 23'h00_2222, 1'b1);
        chk("ack wins", dn, 1);
        chk("no abort line", ar, 0);
        bad_par = 1'b1;
        run(PMRP_OP_READ, 23'h00_3333, 1'b0);
        chk("parity error", pe, 1);
        bad_par = 1'b0;
        $display("abort and parity test done");
    endtask : t_abort
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20) @(negedge mclk);
        chk("reset out", master_reset, 1);
        nrst = 1'b1;
        @(negedge mclk);
        chk("reset out", {master_reset, proc_request}, 0);
        t_mem();
        t_regs();
        t_era();
        t_abort();
        give_verdict();
    end
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule : pmrp_host_tb
